// *** hub_cfg_pkg.sv ***
// Constants for the hub configuration register and its stop grant logic.
// Assumes a dword configuration access port on the system clock.
// Overview of operation
// - Count bus stop grants, then acknowledge on link.
// - Code 000 one grant, 001 two grants.
// - Every thread's stop grant counts separately.
// - Sixteen bit register, resets zero, mixed access.
// - Writable memory frequency select, combined with bus speed.
// - Memory I/O clock runs at twice memory clock.
package hub_cfg_pkg;
	localparam logic [7:0] HUB_CFG_OFFSET = 8'hc6;
	localparam logic [7:0] HUB_CFG_DWORD = 8'hc4;
	localparam logic [15:0] HUB_CFG_RESET = 16'h0000;
	localparam logic [15:0] HUB_CFG_WMASK = 16'he000 | 16'h0c00;
	localparam logic [7:0] HUB_CFG_ADDR_MASK = 8'hfc;
	localparam logic [15:0] HUB_CFG_LOW_PAD = 16'h0000;
	localparam logic [31:0] HUB_CFG_RDATA_IDLE = 32'h0000_0000;
	localparam int SGC_LSB = 13;
	localparam int SGC_W = 3;
	localparam int MFS_LSB = 10;
	localparam int MFS_W = 2;
	localparam int HBS_W = 2;
	localparam int SG_CNT_W = 4;
endpackage : hub_cfg_pkg

// *** stop_grant_counter.sv ***
// Counts front-side bus stop grants and pulses one hub link acknowledge.
// Assumes stop grant pulses are one cycle wide and on the same clock.
`timescale 1ns/1ps
module stop_grant_counter #(
	parameter int CODE_W = hub_cfg_pkg::SGC_W,
	parameter int CNT_W = hub_cfg_pkg::SG_CNT_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [CODE_W-1:0] count_code_i,
	input wire logic stop_grant_i,
	output logic ack_o
);
	logic [CNT_W-1:0] seen_reg;
	logic [CNT_W-1:0] seen_next;
	logic ack_reg;
	logic ack_next;
	logic [CNT_W-1:0] target;

	// Reserved codes simply extend the linear count; firmware is expected not to use them.
	assign target = CNT_W'(count_code_i) + CNT_W'(1);

	always_comb begin
		seen_next = seen_reg;
		ack_next = 1'b0;
		if (stop_grant_i) begin
			if (seen_reg + CNT_W'(1) >= target) begin
				seen_next = '0;
				ack_next = 1'b1;
			end else begin
				seen_next = seen_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seen_reg <= '0;
			ack_reg <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			ack_reg <= ack_next;
		end
	end

	assign ack_o = ack_reg;
endmodule : stop_grant_counter

// *** hub_configuration.sv ***
// Hub configuration register with stop grant acknowledge and memory clock ratio logic.
// Assumes a dword configuration port with byte enables on the system clock; bus speed comes from pins.
`timescale 1ns/1ps
module hub_configuration (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	input wire logic stop_grant_i,
	output logic hub_link_ack_o,
	input wire logic [hub_cfg_pkg::HBS_W-1:0] host_bus_speed_i,
	output logic [hub_cfg_pkg::HBS_W+hub_cfg_pkg::MFS_W-1:0] memory_rate_o,
	output logic mem_clk_o,
	output logic mem_io_clk_o
);
	localparam int LANE_W = 8;
	localparam int REG_LANES = 2;
	localparam int LANE_BASE = int'(hub_cfg_pkg::HUB_CFG_OFFSET[1:0]);
	localparam int RATE_W = hub_cfg_pkg::HBS_W + hub_cfg_pkg::MFS_W;
	localparam logic [hub_cfg_pkg::SGC_W-1:0] SGC_RESET =
		hub_cfg_pkg::HUB_CFG_RESET[hub_cfg_pkg::SGC_LSB +: hub_cfg_pkg::SGC_W];
	localparam logic [hub_cfg_pkg::MFS_W-1:0] MFS_RESET =
		hub_cfg_pkg::HUB_CFG_RESET[hub_cfg_pkg::MFS_LSB +: hub_cfg_pkg::MFS_W];

	logic [hub_cfg_pkg::SGC_W-1:0] sgc_reg;
	logic [hub_cfg_pkg::SGC_W-1:0] sgc_next;
	logic [hub_cfg_pkg::MFS_W-1:0] mfs_reg;
	logic [hub_cfg_pkg::MFS_W-1:0] mfs_next;
	logic [15:0] cfg_view;
	logic [15:0] wr_merge;
	logic wr_hit;
	logic rd_hit;

	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;

	logic [hub_cfg_pkg::HBS_W-1:0] hbs_meta_reg;
	logic [hub_cfg_pkg::HBS_W-1:0] hbs_meta_next;
	logic [hub_cfg_pkg::HBS_W-1:0] hbs_sync_reg;
	logic [hub_cfg_pkg::HBS_W-1:0] hbs_sync_next;

	logic [RATE_W-1:0] rate_reg;
	logic [RATE_W-1:0] rate_next;
	logic io_clk_reg;
	logic io_clk_next;
	logic mem_clk_reg;
	logic mem_clk_next;

	function automatic logic cfg_hit(input logic [7:0] addr);
		cfg_hit = (addr & hub_cfg_pkg::HUB_CFG_ADDR_MASK) == hub_cfg_pkg::HUB_CFG_DWORD;
	endfunction : cfg_hit

	function automatic logic [hub_cfg_pkg::SGC_W-1:0] grant_code(input logic [15:0] value);
		grant_code = value[hub_cfg_pkg::SGC_LSB +: hub_cfg_pkg::SGC_W];
	endfunction : grant_code

	function automatic logic [hub_cfg_pkg::MFS_W-1:0] freq_code(input logic [15:0] value);
		freq_code = value[hub_cfg_pkg::MFS_LSB +: hub_cfg_pkg::MFS_W];
	endfunction : freq_code

	// Reserved bits have no storage at all, so they can never read back anything but zero.
	function automatic logic [15:0] reg_image(
		input logic [hub_cfg_pkg::SGC_W-1:0] code,
		input logic [hub_cfg_pkg::MFS_W-1:0] freq
	);
		logic [15:0] image;
		image = hub_cfg_pkg::HUB_CFG_RESET;
		image[hub_cfg_pkg::SGC_LSB +: hub_cfg_pkg::SGC_W] = code;
		image[hub_cfg_pkg::MFS_LSB +: hub_cfg_pkg::MFS_W] = freq;
		reg_image = image & hub_cfg_pkg::HUB_CFG_WMASK;
	endfunction : reg_image

	assign wr_hit = cfg_wr_i && cfg_hit(cfg_addr_i);
	assign rd_hit = cfg_hit(cfg_addr_i);
	assign cfg_view = reg_image(sgc_reg, mfs_reg);

	// A lane without its byte enable keeps its old contents.
	for (genvar lane = 0; lane < REG_LANES; lane++) begin : g_lane
		assign wr_merge[lane*LANE_W +: LANE_W] = cfg_be_i[LANE_BASE + lane] ?
			cfg_wdata_i[(LANE_BASE + lane)*LANE_W +: LANE_W] :
			cfg_view[lane*LANE_W +: LANE_W];
	end

	always_comb begin
		if (wr_hit) begin
			sgc_next = grant_code(wr_merge);
		end else begin
			sgc_next = sgc_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sgc_reg <= SGC_RESET;
		end else begin
			sgc_reg <= sgc_next;
		end
	end

	always_comb begin
		if (wr_hit) begin
			mfs_next = freq_code(wr_merge);
		end else begin
			mfs_next = mfs_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mfs_reg <= MFS_RESET;
		end else begin
			mfs_reg <= mfs_next;
		end
	end

	// A read in the same cycle as a write sees the old value; the data then hold until the next read.
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = cfg_rd_i;
		if (cfg_rd_i) begin
			if (rd_hit) begin
				rdata_next = {cfg_view, hub_cfg_pkg::HUB_CFG_LOW_PAD};
			end else begin
				rdata_next = hub_cfg_pkg::HUB_CFG_RDATA_IDLE;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= hub_cfg_pkg::HUB_CFG_RDATA_IDLE;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign cfg_rdata_o = rdata_reg;
	assign cfg_rvalid_o = rvalid_reg;

	stop_grant_counter #(
		.CODE_W(hub_cfg_pkg::SGC_W),
		.CNT_W(hub_cfg_pkg::SG_CNT_W)
	) u_sg (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.count_code_i(sgc_reg),
		.stop_grant_i(stop_grant_i),
		.ack_o(hub_link_ack_o)
	);

	// The bus speed comes from pins, so it passes two flip-flops before the rate logic reads it.
	always_comb begin
		hbs_meta_next = host_bus_speed_i;
		hbs_sync_next = hbs_meta_reg;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hbs_meta_reg <= '0;
			hbs_sync_reg <= '0;
		end else begin
			hbs_meta_reg <= hbs_meta_next;
			hbs_sync_reg <= hbs_sync_next;
		end
	end

	always_comb begin
		rate_next = {hbs_sync_reg, mfs_reg};
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rate_reg <= '0;
		end else begin
			rate_reg <= rate_next;
		end
	end

	always_comb begin
		io_clk_next = ~io_clk_reg;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			io_clk_reg <= 1'b0;
		end else begin
			io_clk_reg <= io_clk_next;
		end
	end

	// The slow clock flips on every other fast edge, so the ratio is fixed by construction.
	always_comb begin
		if (io_clk_reg) begin
			mem_clk_next = ~mem_clk_reg;
		end else begin
			mem_clk_next = mem_clk_reg;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_clk_reg <= 1'b0;
		end else begin
			mem_clk_reg <= mem_clk_next;
		end
	end

	assign memory_rate_o = rate_reg;
	assign mem_io_clk_o = io_clk_reg;
	assign mem_clk_o = mem_clk_reg;
endmodule : hub_configuration

// *** hub_configuration_asserts.sv ***
// Checker on the hub configuration ports.
// Assumes one clock and a bind by name.
`timescale 1ns/1ps
module hub_configuration_asserts (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic cfg_rd_i,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic cfg_rvalid_o,
	input wire logic stop_grant_i,
	input wire logic hub_link_ack_o,
	input wire logic [3:0] memory_rate_o,
	input wire logic mem_clk_o,
	input wire logic mem_io_clk_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence io_tick_s;
		mem_io_clk_o ##1 !mem_io_clk_o ##1 mem_io_clk_o;
	endsequence
	read_answer_a: assert property (cfg_rd_i |=> cfg_rvalid_o) else $error("no rvalid");
	low_zero_a: assert property (cfg_rvalid_o |-> cfg_rdata_o[15:0] == 16'h0000) else $error("low bits");
	bit_twelve_a: assert property (cfg_rvalid_o |-> !cfg_rdata_o[28]) else $error("bit 12");
	ack_cause_a: assert property (hub_link_ack_o |-> $past(stop_grant_i)) else $error("stray ack");
	rate_match_a: assert property (cfg_rvalid_o && $past(cfg_addr_i[7:2]) == 6'h31
		|-> cfg_rdata_o[27:26] == memory_rate_o[1:0]) else $error("rate");
	io_clock_a: assert property (mem_io_clk_o |-> io_tick_s) else $error("io clock");
	mem_clock_a: assert property ($changed(mem_clk_o) |=> $stable(mem_clk_o)) else $error("mem clock");
endmodule : hub_configuration_asserts
bind hub_configuration hub_configuration_asserts u_chk (.*);

// *** stop_grant_source.sv ***
// Model of the processor threads issuing stop grants.
// Assumes calls from the bench on the system clock.
`timescale 1ns/1ps
module stop_grant_source (
	input wire logic clk_sys_i,
	output logic stop_grant_o
);
	initial stop_grant_o = 1'b0;
	// A gap of zero sends grants back to back, as many threads can.
	task automatic send(input int n, input int gap);
		repeat (n) begin
			@(posedge clk_sys_i) stop_grant_o <= 1'b1;
			repeat (gap) @(posedge clk_sys_i) stop_grant_o <= 1'b0;
		end
		@(posedge clk_sys_i) stop_grant_o <= 1'b0;
	endtask : send
endmodule : stop_grant_source

// *** hub_configuration_tb.sv ***
// Self-checking bench for the hub configuration register.
// Assumes the stop grant source model and the bound checker.
`timescale 1ns/1ps
module hub_configuration_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [3:0] cfg_be_i = 4'hf;
	logic cfg_wr_i = 1'b0;
	logic cfg_rd_i = 1'b0;
	logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, d;
	logic cfg_rvalid_o, stop_grant_i, hub_link_ack_o, mem_clk_o, mem_io_clk_o;
	logic [1:0] host_bus_speed_i = 2'h2;
	logic [3:0] memory_rate_o;
	int mismatches = 0, tests_run = 0, acks = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (hub_link_ack_o === 1'b1) acks <= acks + 1;
	hub_configuration u_hub_configuration (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.cfg_addr_i(cfg_addr_i),
		.cfg_be_i(cfg_be_i),
		.cfg_wr_i(cfg_wr_i),
		.cfg_rd_i(cfg_rd_i),
		.cfg_wdata_i(cfg_wdata_i),
		.cfg_rdata_o(cfg_rdata_o),
		.cfg_rvalid_o(cfg_rvalid_o),
		.stop_grant_i(stop_grant_i),
		.hub_link_ack_o(hub_link_ack_o),
		.host_bus_speed_i(host_bus_speed_i),
		.memory_rate_o(memory_rate_o),
		.mem_clk_o(mem_clk_o),
		.mem_io_clk_o(mem_io_clk_o)
	);
	stop_grant_source u_stop_grant_source (.clk_sys_i(clk_sys_i), .stop_grant_o(stop_grant_i));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_i) cfg_wr_i <= 1'b1;
		cfg_addr_i <= a;
		cfg_wdata_i <= v;
		@(posedge clk_sys_i) cfg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i) cfg_rd_i <= 1'b1;
		cfg_addr_i <= a;
		@(posedge clk_sys_i) cfg_rd_i <= 1'b0;
		#1 d = cfg_rdata_o;
		chk("read valid", 32'h0000_0001, {31'h0, cfg_rvalid_o});
	endtask : rd
	task automatic t_access;
		rd(8'hc4);
		chk("reset value", 32'h0000_0000, d);
		wr(8'hc8, 32'hffff_ffff);
		rd(8'hc4);
		chk("other dword write", 32'h0000_0000, d);
		wr(8'hc6, 32'hffff_ffff);
		rd(8'hc4);
		chk("writable bits", 32'hec00_0000, d);
		chk("memory rate", 32'h0000_000b, {28'h0, memory_rate_o});
		@(posedge clk_sys_i) host_bus_speed_i <= 2'h1;
		repeat (4) @(posedge clk_sys_i);
		chk("memory rate new speed", 32'h0000_0007, {28'h0, memory_rate_o});
		rd(8'h10);
		chk("unmapped read", 32'h0000_0000, d);
	endtask : t_access
	// Firmware sets the count before any grant arrives and holds it while grants flow.
	task automatic t_grants(input logic [2:0] c, input int n, input int gap);
		int start;
		wr(8'hc6, {c, 29'h0});
		start = acks;
		u_stop_grant_source.send(n, gap);
		repeat (2) @(posedge clk_sys_i);
		chk("ack count", n / (c + 1), acks - start);
	endtask : t_grants
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_access();
		t_grants(3'h0, 3, 0);
		t_grants(3'h1, 4, 0);
		t_grants(3'h1, 2, 3);
		complete_run();
	end
	initial begin
		#20000;
		mismatches++;
		complete_run();
	end
endmodule : hub_configuration_tb
